// ===== rtl/rst_seq_pkg.sv
// Constants and types shared by the reset cause and init sequencer.
package rst_seq_pkg;

   // *****************************************************************
   // Register map
   // *****************************************************************
   localparam logic [11:0] ADDR_CAUSE_STATUS = 12'hFCC;
   localparam logic [11:0] ADDR_SYSTEM_KEY   = 12'hFDF;
   localparam logic [11:0] ADDR_CTRL         = 12'hF00;
   localparam logic [11:0] ADDR_SEQ_STATUS   = 12'hF04;
   localparam logic [7:0]  KEY_FLAG_CLEAR    = 8'h71;
   localparam logic [7:0]  CAUSE_RESET       = 8'h00;
   localparam int          BIT_CLEAR_REQ     = 7;
   localparam int          BIT_TRIM_BAD      = 5;
   localparam int          NUM_SOURCES       = 6;
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   // *****************************************************************
   // CPU reset state
   // *****************************************************************
   localparam logic [15:0] PC_MCU      = 16'hFFFE;
   localparam logic [15:0] PC_SERIAL   = 16'h1FFE;
   localparam logic [15:0] SP_RESET    = 16'h00FF;
   localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
   localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;

   // *****************************************************************
   // Timing
   // *****************************************************************
   localparam int          CLK_MHZ       = 250;
   localparam int          WARMUP_US     = 10;
   localparam int          WARMUP_CYCLES = WARMUP_US * CLK_MHZ;
   localparam int          WU_W          = 16;
   localparam logic [WU_W-1:0] WU_ONE    = 16'h0001;
   localparam int          TRIM_W        = 8;
   localparam logic [2:0]  TRIM_ADDR     = 3'h0;

   typedef enum logic [2:0] {ST_RESET, ST_WARMUP, ST_VEC_LO, ST_VEC_HI, ST_RUN} seq_t;

endpackage : rst_seq_pkg

// ===== rtl/trim_store.sv
// Small non-volatile trim storage model with registered read data.
`timescale 1ns/1ps
`default_nettype none
module trim_store
   import rst_seq_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [2:0]        addr,
   input  wire logic [TRIM_W-1:0] wdata,
   input  wire logic              we,
   output var  logic [TRIM_W-1:0] rdata
);
   logic [TRIM_W-1:0] mem [0:7];

   // Read data come out of a register so the sequencer samples it one cycle later.
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : trim_store
`default_nettype wire

// ===== rtl/reset_cause_and_init_sequencer.sv
// Reset merging, warm-up sequencing and the reset cause status register.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_init_sequencer
   import rst_seq_pkg::*;
#(
   parameter int WARMUP_COUNT = WARMUP_CYCLES
)
(
   input  wire logic                   SYS_CLK,
   input  wire logic                   RESET_N,
   input  wire logic                   POR_ACTIVE,
   input  wire logic                   PIN_RESET_N,
   input  wire logic [NUM_SOURCES-1:0] INT_RESET_REQ,
   input  wire logic                   SERIAL_MODE,
   input  wire logic [TRIM_W-1:0]      TRIM_LOAD_DATA,
   input  wire logic                   TRIM_LOAD_WE,
   input  wire logic [7:0]             VECTOR_DATA,
   output logic                        CPU_RESET_N,
   output logic                        PERIPH_RESET_N,
   output logic [15:0]                 PC,
   output logic [15:0]                 SP,
   output logic [15:0]                 VECTOR_ADDR,
   output logic                        INTERRUPT_MASTER_ENABLE,
   output logic                        INTERRUPT_ENABLE_BITS_CLR,
   output logic                        INTERRUPT_LATCH_CLR,
   output logic                        REGISTER_BANK_SELECT,
   output logic                        HF_OSC_EN,
   output logic                        LF_OSC_EN,
   output logic                        TG_CLEAR,
   output logic                        WDT_EN,
   output logic                        PORT_HIZ,
   output logic                        VDET_DISABLE,
   output logic [TRIM_W-1:0]           TRIM_VALUE,
   input  wire logic [11:0]            S_AXI_AWADDR,
   input  wire logic                   S_AXI_AWVALID,
   output logic                        S_AXI_AWREADY,
   input  wire logic [31:0]            S_AXI_WDATA,
   input  wire logic [3:0]             S_AXI_WSTRB,
   input  wire logic                   S_AXI_WVALID,
   output logic                        S_AXI_WREADY,
   output logic [1:0]                  S_AXI_BRESP,
   output logic                        S_AXI_BVALID,
   input  wire logic                   S_AXI_BREADY,
   input  wire logic [11:0]            S_AXI_ARADDR,
   input  wire logic                   S_AXI_ARVALID,
   output logic                        S_AXI_ARREADY,
   output logic [31:0]                 S_AXI_RDATA,
   output logic [1:0]                  S_AXI_RRESP,
   output logic                        S_AXI_RVALID,
   input  wire logic                   S_AXI_RREADY
);

   // *****************************************************************
   // State
   // *****************************************************************
   typedef struct packed {
      seq_t                   seq;
      logic [WU_W-1:0]        wu_count;
      logic [6:0]             flags;
      logic                   clear_req;
      logic                   trim_check;
      logic [TRIM_W-1:0]      trim;
      logic [15:0]            pc;
      logic [7:0]             vec_lo;
      logic                   vdet_dis;
      logic                   user_vdet_en;
      logic                   aw_held;
      logic [11:0]            awaddr;
      logic                   w_held;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
   } state_t;

   state_t st;
   state_t next_st;
   logic [TRIM_W-1:0] trim_rdata;
   logic              ext_reset;
   logic              any_reset;
   logic              wr_fire;

   // Trim data storage; read continuously from one fixed word.
   trim_store u_trim
   (
      .clk   (SYS_CLK),
      .addr  (TRIM_ADDR),
      .wdata (TRIM_LOAD_DATA),
      .we    (TRIM_LOAD_WE),
      .rdata (trim_rdata)
   );

   // Erased or stuck storage is taken as abnormal trim data.
   function automatic logic trim_bad(input logic [TRIM_W-1:0] d);
      trim_bad = (d == {TRIM_W{1'b0}}) || (d == {TRIM_W{1'b1}});
   endfunction : trim_bad

   // Read mux shared by the status and control views.
   function automatic logic [31:0] read_word(input state_t s, input logic [11:0] a);
      read_word = 32'h0000_0000;
      case (a)
         ADDR_CAUSE_STATUS: read_word = {25'h0, s.flags};
         ADDR_CTRL:         read_word = {31'h0, s.user_vdet_en};
         ADDR_SEQ_STATUS:   read_word = {29'h0, s.seq};
         default:           read_word = 32'h0000_0000;
      endcase
   endfunction : read_word

   // Power-on and pin reset are ORed into the external reset.
   assign ext_reset = POR_ACTIVE || !PIN_RESET_N;
   assign any_reset = ext_reset || (|INT_RESET_REQ) || !RESET_N;

   // *****************************************************************
   // Next state
   // *****************************************************************
   always_comb
   begin
      next_st = st;
      next_st.trim_check = 1'b0;
      // Bus channels: take address and data in either order.
      if (S_AXI_AWVALID && !st.aw_held && !st.bvalid)
      begin
         next_st.aw_held = 1'b1;
         next_st.awaddr  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !st.w_held && !st.bvalid)
      begin
         next_st.w_held = 1'b1;
         next_st.wdata  = S_AXI_WDATA;
         next_st.wstrb  = S_AXI_WSTRB;
      end
      wr_fire = next_st.aw_held && next_st.w_held && !st.bvalid;
      if (st.bvalid && S_AXI_BREADY)
      begin
         next_st.bvalid = 1'b0;
      end
      if (wr_fire)
      begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = RESP_OKAY;
         case (next_st.awaddr)
            ADDR_CAUSE_STATUS:
            begin
               if (next_st.wstrb[0])
               begin
                  next_st.clear_req = next_st.wdata[BIT_CLEAR_REQ];
               end
            end
            ADDR_SYSTEM_KEY:
            begin
               // Clear fires only on the key with the request armed.
               if (next_st.wstrb[0] && next_st.wdata[7:0] == KEY_FLAG_CLEAR && st.clear_req)
               begin
                  next_st.flags     = CAUSE_RESET[6:0];
                  next_st.clear_req = 1'b0;
               end
            end
            ADDR_CTRL:
            begin
               if (next_st.wstrb[0])
               begin
                  next_st.user_vdet_en = next_st.wdata[0];
               end
            end
            ADDR_SEQ_STATUS: next_st.bresp = RESP_OKAY;
            default:         next_st.bresp = RESP_SLVERR;
         endcase
      end
      if (st.rvalid && S_AXI_RREADY)
      begin
         next_st.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && !st.rvalid)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = read_word(st, S_AXI_ARADDR);
         next_st.rresp  = (S_AXI_ARADDR == ADDR_CAUSE_STATUS || S_AXI_ARADDR == ADDR_SYSTEM_KEY ||
                           S_AXI_ARADDR == ADDR_CTRL || S_AXI_ARADDR == ADDR_SEQ_STATUS)
                          ? RESP_OKAY : RESP_SLVERR;
      end
      // Internal sources set their own flags; set wins over a same-cycle key clear but not over a same-cycle power-on or pin reset.
      // Flash standby skips the trim status bit and lands one place higher.
      next_st.flags[BIT_TRIM_BAD-1:0] |= INT_RESET_REQ[BIT_TRIM_BAD-1:0];
      next_st.flags[BIT_TRIM_BAD+1]   |= INT_RESET_REQ[NUM_SOURCES-1];
      if (st.trim_check && trim_bad(trim_rdata))
      begin
         next_st.flags[BIT_TRIM_BAD] = 1'b1;
      end
      // Sequencer.
      case (st.seq)
         ST_RESET:
         begin
            next_st.wu_count = '0;
            next_st.pc       = SERIAL_MODE ? PC_SERIAL : PC_MCU;
            if (!any_reset)
            begin
               next_st.seq        = ST_WARMUP;
               next_st.trim_check = 1'b1;
            end
         end
         ST_WARMUP:
         begin
            next_st.wu_count = st.wu_count + WU_ONE;
            next_st.trim     = trim_rdata;
            if (st.wu_count == WU_W'(WARMUP_COUNT - 1))
            begin
               next_st.seq = ST_VEC_LO;
            end
         end
         // The low byte stands on the data input while the low address is out.
         ST_VEC_LO:
         begin
            next_st.vec_lo = VECTOR_DATA;
            next_st.seq    = ST_VEC_HI;
         end
         // PC takes the vector as the CPU leaves reset, never earlier.
         ST_VEC_HI:
         begin
            next_st.pc  = {VECTOR_DATA, st.vec_lo};
            next_st.seq = ST_RUN;
         end
         ST_RUN: next_st.seq = ST_RUN;
         default: next_st.seq = ST_RESET;
      endcase
      // A new reset restarts warm-up from zero.
      if (any_reset)
      begin
         next_st.seq      = ST_RESET;
         next_st.wu_count = '0;
         next_st.pc       = SERIAL_MODE ? PC_SERIAL : PC_MCU;
      end
      // Power-on or pin reset clears flags and disables detectors; internal sources clear no flags and leave the detectors alone.
      if (ext_reset)
      begin
         next_st.flags        = CAUSE_RESET[6:0];
         next_st.clear_req    = 1'b0;
         next_st.vdet_dis     = 1'b1;
         next_st.user_vdet_en = 1'b0;
      end
      else if (next_st.user_vdet_en)
      begin
         next_st.vdet_dis = 1'b0;
      end
   end

   // *****************************************************************
   // Registers
   // *****************************************************************
   // The system reset clears all state but pc and vdet_dis, which load PC_MCU and 1; flags also survive only internal causes.
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         st          <= '0;
         st.seq      <= ST_RESET;
         st.pc       <= PC_MCU;
         st.vdet_dis <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // *****************************************************************
   // Outputs
   // *****************************************************************
   // Outputs are registered; held-in-reset values derive from the next state.
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         CPU_RESET_N               <= 1'b0;
         PERIPH_RESET_N            <= 1'b0;
         PC                        <= PC_MCU;
         SP                        <= SP_RESET;
         VECTOR_ADDR               <= VEC_LO_ADDR;
         INTERRUPT_MASTER_ENABLE   <= 1'b0;
         INTERRUPT_ENABLE_BITS_CLR <= 1'b1;
         INTERRUPT_LATCH_CLR       <= 1'b1;
         REGISTER_BANK_SELECT      <= 1'b0;
         HF_OSC_EN                 <= 1'b1;
         LF_OSC_EN                 <= 1'b0;
         TG_CLEAR                  <= 1'b1;
         WDT_EN                    <= 1'b0;
         PORT_HIZ                  <= 1'b1;
         VDET_DISABLE              <= 1'b1;
         TRIM_VALUE                <= '0;
      end
      else
      begin
         CPU_RESET_N               <= (next_st.seq == ST_RUN);
         PERIPH_RESET_N            <= (next_st.seq == ST_RUN);
         PC                        <= next_st.pc;
         SP                        <= SP_RESET;
         VECTOR_ADDR               <= (next_st.seq == ST_VEC_HI) ? VEC_HI_ADDR : VEC_LO_ADDR;
         INTERRUPT_MASTER_ENABLE   <= 1'b0;
         INTERRUPT_ENABLE_BITS_CLR <= (next_st.seq != ST_RUN);
         INTERRUPT_LATCH_CLR       <= (next_st.seq != ST_RUN);
         REGISTER_BANK_SELECT      <= 1'b0;
         HF_OSC_EN                 <= 1'b1;
         LF_OSC_EN                 <= 1'b0;
         TG_CLEAR                  <= (next_st.seq != ST_RUN);
         WDT_EN                    <= (next_st.seq == ST_RUN) || (next_st.seq == ST_VEC_LO)
                                      || (next_st.seq == ST_VEC_HI);
         PORT_HIZ                  <= 1'b1;
         VDET_DISABLE              <= next_st.vdet_dis;
         TRIM_VALUE                <= next_st.trim;
      end
   end

   // AXI outputs straight from state flops.
   assign S_AXI_AWREADY = st.aw_held == 1'b0 && st.bvalid == 1'b0;
   assign S_AXI_WREADY  = st.w_held == 1'b0 && st.bvalid == 1'b0;
   assign S_AXI_BVALID  = st.bvalid;
   assign S_AXI_BRESP   = st.bresp;
   assign S_AXI_ARREADY = !st.rvalid;
   assign S_AXI_RVALID  = st.rvalid;
   assign S_AXI_RDATA   = st.rdata;
   assign S_AXI_RRESP   = st.rresp;

endmodule : reset_cause_and_init_sequencer
`default_nettype wire

// ===== dv/rst_seq_assertions.sv
// Port-level checker for the reset cause and init sequencer.
`timescale 1ns/1ps
`default_nettype none
module rst_seq_checker
   import rst_seq_pkg::*;
#(
   parameter int WARMUP_COUNT = 8
)
(
   input wire logic                   SYS_CLK,
   input wire logic                   RESET_N,
   input wire logic                   POR_ACTIVE,
   input wire logic                   PIN_RESET_N,
   input wire logic [NUM_SOURCES-1:0] INT_RESET_REQ,
   input wire logic                   SERIAL_MODE,
   input wire logic                   CPU_RESET_N,
   input wire logic                   PERIPH_RESET_N,
   input wire logic [15:0]            PC,
   input wire logic [15:0]            SP,
   input wire logic                   INTERRUPT_MASTER_ENABLE,
   input wire logic                   INTERRUPT_ENABLE_BITS_CLR,
   input wire logic                   INTERRUPT_LATCH_CLR,
   input wire logic                   REGISTER_BANK_SELECT,
   input wire logic                   HF_OSC_EN,
   input wire logic                   LF_OSC_EN,
   input wire logic                   TG_CLEAR,
   input wire logic                   WDT_EN,
   input wire logic                   PORT_HIZ,
   input wire logic                   VDET_DISABLE,
   input wire logic                   S_AXI_WVALID,
   input wire logic                   S_AXI_RVALID,
   input wire logic [31:0]            S_AXI_RDATA
);
   // *****************************
   // Helper logic
   // *****************************
   logic src;
   int   quiet;
   // Any reset source at all, the system reset included.
   assign src = !RESET_N || POR_ACTIVE || !PIN_RESET_N || (|INT_RESET_REQ);
   // Cycles since the last source went away; the warm-up is judged on it.
   always_ff @(posedge SYS_CLK)
   begin
      quiet <= src ? 0 : quiet + 1;
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   // *****************************
   // Assertions
   // *****************************
   // Reset holding, warm-up length and the state held until the CPU runs.
   hold_in_reset_a: assert property (src |-> ##[0:2] (!CPU_RESET_N && !PERIPH_RESET_N))
      else $error("CPU or peripherals ran under a reset source");
   warm_length_a: assert property ($rose(CPU_RESET_N) |->
      (quiet >= WARMUP_COUNT && quiet <= WARMUP_COUNT + 6))
      else $error("warm-up length wrong");
   pc_sp_held_a: assert property (!CPU_RESET_N && $past(RESET_N) && $stable(SERIAL_MODE)
      |-> PC == (SERIAL_MODE ? PC_SERIAL : PC_MCU) && SP == SP_RESET)
      else $error("PC or SP not at reset value");
   irq_held_a: assert property (!CPU_RESET_N |-> !INTERRUPT_MASTER_ENABLE && !REGISTER_BANK_SELECT
      && INTERRUPT_ENABLE_BITS_CLR && INTERRUPT_LATCH_CLR)
      else $error("interrupt state not cleared");
   osc_ports_a: assert property (!CPU_RESET_N |-> HF_OSC_EN && !LF_OSC_EN && PORT_HIZ && TG_CLEAR)
      else $error("oscillator, port or timing state wrong");
   wdt_off_a: assert property (src |-> ##[1:2] !WDT_EN)
      else $error("watchdog left on in reset");
   wdt_on_a: assert property ($rose(CPU_RESET_N) |-> WDT_EN && !$past(WDT_EN, WARMUP_COUNT))
      else $error("watchdog not enabled after warm-up");
   vdet_set_a: assert property ((POR_ACTIVE || !PIN_RESET_N) |-> ##[1:2] VDET_DISABLE)
      else $error("detectors not disabled");
   vdet_keep_a: assert property ((|INT_RESET_REQ) && !POR_ACTIVE && PIN_RESET_N && !S_AXI_WVALID
      |=> $stable(VDET_DISABLE))
      else $error("internal reset touched detectors");
   bit7_read_a: assert property (S_AXI_RVALID |-> !S_AXI_RDATA[7])
      else $error("bit seven read as one");
endmodule : rst_seq_checker
bind reset_cause_and_init_sequencer rst_seq_checker #(.WARMUP_COUNT(WARMUP_COUNT)) u_chk (
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .POR_ACTIVE(POR_ACTIVE), .PIN_RESET_N(PIN_RESET_N),
   .INT_RESET_REQ(INT_RESET_REQ), .SERIAL_MODE(SERIAL_MODE), .CPU_RESET_N(CPU_RESET_N),
   .PERIPH_RESET_N(PERIPH_RESET_N), .PC(PC), .SP(SP),
   .INTERRUPT_MASTER_ENABLE(INTERRUPT_MASTER_ENABLE),
   .INTERRUPT_ENABLE_BITS_CLR(INTERRUPT_ENABLE_BITS_CLR),
   .INTERRUPT_LATCH_CLR(INTERRUPT_LATCH_CLR), .REGISTER_BANK_SELECT(REGISTER_BANK_SELECT),
   .HF_OSC_EN(HF_OSC_EN), .LF_OSC_EN(LF_OSC_EN), .TG_CLEAR(TG_CLEAR), .WDT_EN(WDT_EN),
   .PORT_HIZ(PORT_HIZ), .VDET_DISABLE(VDET_DISABLE), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA));
`default_nettype wire

// ===== dv/vector_rom_model.sv
// Reset vector memory on the CPU side of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module vector_rom_model
   import rst_seq_pkg::*;
#(
   parameter logic [15:0] VECTOR = 16'h4A3C
)
(
   input  wire logic        clk,
   input  wire logic [15:0] addr,
   output var  logic [7:0]  data
);
   logic [7:0] junk = 8'hA5;
   // Off the vector bytes the data churns, so a stray fetch never sees a steady byte.
   always_ff @(posedge clk)
   begin
      junk <= junk + 8'h5B;
   end
   // Low byte first at the two top addresses.
   always_comb
   begin
      if (addr == VEC_LO_ADDR)
         data = VECTOR[7:0];
      else if (addr == VEC_HI_ADDR)
         data = VECTOR[15:8];
      else
         data = junk;
   end
endmodule : vector_rom_model
`default_nettype wire

// ===== dv/reset_cause_and_init_sequencer_tb.sv
// Self-checking bench for the reset cause and init sequencer.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_init_sequencer_tb
   import rst_seq_pkg::*;
   ;
   localparam int          WU  = 8;
   localparam logic [15:0] VEC = 16'h4A3C;
   logic        sys_clk = 1'b0;
   logic        reset_n, por_active, pin_reset_n, serial_mode, trim_we;
   logic [5:0]  int_req;
   logic [7:0]  trim_data, vec_data, trim_val, rd;
   logic [15:0] pc, vec_addr;
   logic        cpu_rst_n, wdt_en, vdet_dis;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [7:0]  exp;
   int          failures = 0;
   int          tests_run = 0;
   // A 4 ns clock.
   always #2 sys_clk = ~sys_clk;
   reset_cause_and_init_sequencer #(.WARMUP_COUNT(WU)) u_dut (
      .SYS_CLK(sys_clk), .RESET_N(reset_n), .POR_ACTIVE(por_active), .PIN_RESET_N(pin_reset_n),
      .INT_RESET_REQ(int_req), .SERIAL_MODE(serial_mode), .TRIM_LOAD_DATA(trim_data),
      .TRIM_LOAD_WE(trim_we), .VECTOR_DATA(vec_data), .CPU_RESET_N(cpu_rst_n),
      .PERIPH_RESET_N(), .PC(pc), .SP(), .VECTOR_ADDR(vec_addr), .INTERRUPT_MASTER_ENABLE(),
      .INTERRUPT_ENABLE_BITS_CLR(), .INTERRUPT_LATCH_CLR(), .REGISTER_BANK_SELECT(),
      .HF_OSC_EN(), .LF_OSC_EN(), .TG_CLEAR(), .WDT_EN(wdt_en), .PORT_HIZ(),
      .VDET_DISABLE(vdet_dis), .TRIM_VALUE(trim_val), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   vector_rom_model #(.VECTOR(VEC)) u_rom (.clk(sys_clk), .addr(vec_addr), .data(vec_data));
   // ****************************
   // Reporting
   // ****************************
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic timed_out(input string what);
      failures++;
      $display("BAD %0t timeout on %s", $time, what);
      test_done();
   endtask : timed_out
   task automatic check_val(input logic [15:0] got, input logic [15:0] want, input string what);
      tests_run++;
      if (got !== want)
      begin
         failures++;
         $display("BAD %0t %s got %h want %h", $time, what, got, want);
      end
   endtask : check_val
   // ****************************
   // Bus and stimulus tasks
   // ****************************
   // Ready is sampled at the falling edge, so its level is the one the next rising edge sees.
   task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
      logic a_hit, w_hit, b_hit;
      int   n;
      @(posedge sys_clk);
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(negedge sys_clk);
         a_hit = awvalid && awready;
         w_hit = wvalid && wready;
         b_hit = bvalid;
         r     = bresp;
         @(posedge sys_clk);
         if (a_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         if (b_hit) break;
      end
      bready <= 1'b0;
      if (n == 64) timed_out("write");
   endtask : axi_write
   task automatic axi_read(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
      logic a_hit, r_hit;
      int   n;
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(negedge sys_clk);
         a_hit = arvalid && arready;
         r_hit = rvalid;
         d     = rdata[7:0];
         r     = rresp;
         @(posedge sys_clk);
         if (a_hit) arvalid <= 1'b0;
         if (r_hit) break;
      end
      rready <= 1'b0;
      if (n == 64) timed_out("read");
   endtask : axi_read
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      axi_write(a, d, rsp);
      check_val({14'h0, rsp}, {14'h0, RESP_OKAY}, "bresp");
   endtask : wr
   task automatic expect_reg(input logic [11:0] a, input logic [7:0] want);
      axi_read(a, rd, rsp);
      check_val({14'h0, rsp}, {14'h0, RESP_OKAY}, "rresp");
      check_val({8'h00, rd}, {8'h00, want}, "rdata");
   endtask : expect_reg
   task automatic wait_run();
      int n;
      for (n = 0; n < 200 && cpu_rst_n !== 1'b1; n++)
         @(negedge sys_clk);
      if (n == 200) timed_out("run");
   endtask : wait_run
   // Hold the chosen sources three cycles, release them and wait for the CPU.
   task automatic pulse_src(input logic por, input logic pin, input logic [5:0] irq);
      @(posedge sys_clk);
      por_active  <= por;
      pin_reset_n <= !pin;
      int_req     <= irq;
      repeat (3) @(posedge sys_clk);
      por_active  <= 1'b0;
      pin_reset_n <= 1'b1;
      int_req     <= 6'h00;
      wait_run();
   endtask : pulse_src
   task automatic load_trim(input logic [7:0] v);
      @(posedge sys_clk);
      trim_data <= v;
      trim_we   <= 1'b1;
      @(posedge sys_clk);
      trim_we   <= 1'b0;
   endtask : load_trim
   // ****************************
   // Scenarios
   // ****************************
   task automatic t_boot();
      load_trim(8'h5A);
      pulse_src(1'b1, 1'b0, 6'h00);
      @(negedge sys_clk);
      check_val(pc, VEC, "start pc");
      check_val({15'h0, wdt_en}, 16'h0001, "watchdog");
      check_val({15'h0, vdet_dis}, 16'h0001, "vdet off");
      check_val({8'h00, trim_val}, 16'h005A, "trim");
      expect_reg(ADDR_CAUSE_STATUS, 8'h00);
      expect_reg(ADDR_SEQ_STATUS, 8'h04);
      expect_reg(ADDR_SYSTEM_KEY, 8'h00);
   endtask : t_boot
   // Every internal source once; flags pile up and the detectors stay as set.
   task automatic t_flags();
      wr(ADDR_CTRL, 8'h01);
      exp = 8'h00;
      for (int i = 0; i < NUM_SOURCES; i++)
      begin
         serial_mode <= (i == 2);
         pulse_src(1'b0, 1'b0, 6'h01 << i);
         exp = exp | ((i == 5) ? 8'h40 : (8'h01 << i));
         expect_reg(ADDR_CAUSE_STATUS, exp);
         check_val({15'h0, vdet_dis}, 16'h0000, "vdet kept");
      end
      serial_mode <= 1'b0;
   endtask : t_flags
   task automatic t_clear();
      wr(ADDR_CAUSE_STATUS, 8'h80);
      expect_reg(ADDR_CAUSE_STATUS, exp);
      wr(ADDR_SYSTEM_KEY, 8'h55);
      expect_reg(ADDR_CAUSE_STATUS, exp);
      wr(ADDR_SYSTEM_KEY, KEY_FLAG_CLEAR);
      expect_reg(ADDR_CAUSE_STATUS, 8'h00);
      pulse_src(1'b0, 1'b0, 6'h01);
      wr(ADDR_SYSTEM_KEY, KEY_FLAG_CLEAR);
      expect_reg(ADDR_CAUSE_STATUS, 8'h01);
   endtask : t_clear
   // A second pin reset in mid warm-up; then trim data that reads as bad.
   task automatic t_pin_trim();
      load_trim(8'h00);
      @(posedge sys_clk);
      pin_reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      pin_reset_n <= 1'b1;
      repeat (WU / 2) @(posedge sys_clk);
      @(negedge sys_clk);
      check_val({15'h0, cpu_rst_n}, 16'h0000, "held");
      pulse_src(1'b0, 1'b1, 6'h00);
      expect_reg(ADDR_CAUSE_STATUS, 8'h20);
      check_val({15'h0, vdet_dis}, 16'h0001, "vdet off");
      load_trim(8'h5A);
      pulse_src(1'b0, 1'b0, 6'h01);
      expect_reg(ADDR_CAUSE_STATUS, 8'h21);
      axi_read(12'h010, rd, rsp);
      check_val({14'h0, rsp}, {14'h0, RESP_SLVERR}, "unmapped read");
      axi_write(12'h010, 8'hFF, rsp);
      check_val({14'h0, rsp}, {14'h0, RESP_SLVERR}, "unmapped write");
   endtask : t_pin_trim
   initial
   begin
      {reset_n, por_active, serial_mode, trim_we} = 4'h0;
      pin_reset_n = 1'b1;
      int_req = 6'h00;
      trim_data = 8'h00;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_boot();
      t_flags();
      t_clear();
      t_pin_trim();
      test_done();
   end
endmodule : reset_cause_and_init_sequencer_tb
`default_nettype wire
